// File: core/lbh_pkg.sv
package lbh_pkg;
  // cycle type codes presented by the internal bus unit
  localparam logic [2:0] CYC_INTA = 3'h0;
  localparam logic [2:0] CYC_IORD = 3'h1;
  localparam logic [2:0] CYC_IOWR = 3'h2;
  localparam logic [2:0] CYC_HALT = 3'h3;
  localparam logic [2:0] CYC_FETCH = 3'h4;
  localparam logic [2:0] CYC_MEMRD = 3'h5;
  localparam logic [2:0] CYC_MEMWR = 3'h6;
  localparam logic [2:0] CYC_PASSIVE = 3'h7;
  // register map of the select and mode registers
  localparam logic [3:0] OFF_UMCS = 4'h0;
  localparam logic [3:0] OFF_LMCS = 4'h1;
  localparam logic [3:0] OFF_MBASE = 4'h2;
  localparam logic [3:0] OFF_MSIZE = 4'h3;
  localparam logic [3:0] OFF_PBASE = 4'h4;
  localparam logic [3:0] OFF_PCTL = 4'h5;
  localparam logic [3:0] OFF_STAT = 4'h6;
  // field positions in the peripheral control register
  localparam int PCTL_MEM_BIT = 0;
  localparam int PCTL_A1_BIT = 1;
  localparam int PCTL_A2_BIT = 2;
  localparam int PCTL_ENH_BIT = 3;
  // reset values: upper block 1K at the top, lower and mid ranges closed, peripheral blocks open in io space at 0
  localparam logic [15:0] UMCS_RST = 16'hffc0;
  localparam logic [15:0] LMCS_RST = 16'h0000;
  localparam logic [15:0] MBASE_RST = 16'h0000;
  localparam logic [15:0] MSIZE_RST = 16'h0000;
  localparam logic [15:0] PBASE_RST = 16'h0000;
  localparam logic [15:0] PCTL_RST = 16'h0000;
  // bus ownership states
  typedef enum logic [3:0] {
    LBH_OWN = 4'b0001,
    LBH_GRANT = 4'b0010,
    LBH_RECLAIM = 4'b0100,
    LBH_IDLE_REL = 4'b1000
  } lbh_state_e;
endpackage

// File: core/lbh_core.sv
`timescale 1ns/1ns
// How it works
// - status outputs float whenever the bus is granted away
// - top status bit separates memory cycles from io cycles
// - grant rises together with floating address/data and control lines
// - grant drops after request low; bus stays floated until the core starts a cycle or a refresh is pending
// - enhanced mode drops grant while a refresh is pending
// - upper select low for accesses in programmed upper block 1K-256K
// - lower select low for accesses in programmed lower block 1K-256K
// - memory and peripheral selects stay driven during grant
// - both memory selects low at reset release enters test mode
// - test mode floats every output until the next reset
// - weak pull-up on memory select pins during reset and until the first clock after release
// - four mid-range selects cover programmed quarters of 8K-512K region
// - five peripheral selects in io space or memory space
// - option makes sixth select a latched address bit 1, held in grant
// - option makes seventh select a latched address bit 2, held in grant
// - direction low on reads, high on writes
// - direction floats during grant and reset
// - enable low during accesses, high at every direction change
// - enable high one clock in reset then floats; floats in grant
// - lock output floats during grant and reset
module lbh_core (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic bus_request_in,
  input wire logic refresh_pending,
  input wire logic cyc_start,
  input wire logic [2:0] cyc_type,
  input wire logic [19:0] cyc_addr,
  input wire logic cyc_data_phase,
  input wire logic cyc_done,
  input wire logic lock_req,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic bus_grant_out,
  output logic bus_grant_oe_n,
  output logic local_bus_oe_n,
  output logic cycle_status_bit2,
  output logic cycle_status_bit1,
  output logic cycle_status_bit0,
  output logic status_oe_n,
  input wire logic upper_sel_pin_in,
  input wire logic lower_sel_pin_in,
  output logic upper_mem_select_n,
  output logic lower_mem_select_n,
  output logic mem_select_oe_n,
  output logic mem_select_pullup_en,
  output logic [3:0] midrange_mem_select_n,
  output logic [4:0] periph_select_n,
  output logic periph_sel5_or_latched_addr1,
  output logic periph_sel6_or_latched_addr2,
  output logic periph_oe_n,
  output logic transceiver_direction,
  output logic transceiver_direction_oe_n,
  output logic transceiver_output_enable_n,
  output logic transceiver_output_enable_oe_n,
  output logic bus_lock_n,
  output logic bus_lock_oe_n,
  output logic test_mode
);
  lbh_pkg::lbh_state_e state_reg;
  lbh_pkg::lbh_state_e state_next;
  logic req_reg;
  logic in_cycle_reg;
  logic granted;
  logic reset_seen_reg;
  logic den_rst_reg;
  logic den_float_reg;
  logic [15:0] umcs_reg;
  logic [15:0] lmcs_reg;
  logic [15:0] mbase_reg;
  logic [15:0] msize_reg;
  logic [15:0] pbase_reg;
  logic [15:0] pctl_reg;
  logic [2:0] status_reg;
  logic is_mem;
  logic hit_u;
  logic hit_l;
  logic [3:0] hit_m;
  logic [6:0] hit_p;
  logic [12:0] sel_next;
  logic [12:0] sel_reg;
  logic a1_reg;
  logic a2_reg;
  logic dir_reg;
  logic den_n_reg;
  logic lock_reg;
  logic [19:0] m_size20;
  logic [19:0] m_off;
  logic [19:0] p_off;

  // request is registered so a glitch on the pin reaches the grant only if it spans a clock edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      req_reg <= 1'b0;
    end else begin
      req_reg <= bus_request_in;
    end
  end

  // track whether a bus cycle is in flight so grant waits for its boundary
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      in_cycle_reg <= 1'b0;
    end else if (cyc_done) begin
      in_cycle_reg <= 1'b0;
    end else if (cyc_start && !granted) begin
      in_cycle_reg <= 1'b1;
    end
  end

  // ownership state machine
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      lbh_pkg::LBH_OWN: begin
        if (req_reg && !in_cycle_reg && !cyc_start) begin
          state_next = lbh_pkg::LBH_GRANT;
        end
      end
      lbh_pkg::LBH_GRANT: begin
        if (!req_reg) begin
          state_next = lbh_pkg::LBH_IDLE_REL;
        end else if (pctl_reg[lbh_pkg::PCTL_ENH_BIT] && refresh_pending) begin
          state_next = lbh_pkg::LBH_RECLAIM;
        end
      end
      lbh_pkg::LBH_RECLAIM: begin
        if (!req_reg) begin
          state_next = lbh_pkg::LBH_IDLE_REL;
        end
      end
      lbh_pkg::LBH_IDLE_REL: begin
        // bus stays floated until the core next wants a cycle
        if (cyc_start || refresh_pending) begin
          state_next = lbh_pkg::LBH_OWN;
        end else if (req_reg) begin
          state_next = lbh_pkg::LBH_GRANT;
        end
      end
      default: state_next = lbh_pkg::LBH_OWN;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= lbh_pkg::LBH_OWN;
    end else begin
      state_reg <= state_next;
    end
  end

  assign granted = (state_reg == lbh_pkg::LBH_GRANT) || (state_reg == lbh_pkg::LBH_RECLAIM);

  // catch the select pins on the first clock after reset release
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reset_seen_reg <= 1'b0;
      test_mode <= 1'b0;
    end else if (!reset_seen_reg) begin
      reset_seen_reg <= 1'b1;
      test_mode <= !upper_sel_pin_in && !lower_sel_pin_in;
    end
  end

  // enable is held high through reset and until the first clock after reset release
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      den_rst_reg <= 1'b1;
    end else begin
      den_rst_reg <= 1'b0;
    end
  end

  // reset is read as data here: an async clear could not count the one driven clock inside reset
  always_ff @(posedge clk) begin
    den_float_reg <= !arst_n;
  end

  // register writes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      umcs_reg <= lbh_pkg::UMCS_RST;
      lmcs_reg <= lbh_pkg::LMCS_RST;
      mbase_reg <= lbh_pkg::MBASE_RST;
      msize_reg <= lbh_pkg::MSIZE_RST;
      pbase_reg <= lbh_pkg::PBASE_RST;
      pctl_reg <= lbh_pkg::PCTL_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        lbh_pkg::OFF_UMCS: umcs_reg <= reg_wdata;
        lbh_pkg::OFF_LMCS: lmcs_reg <= reg_wdata;
        lbh_pkg::OFF_MBASE: mbase_reg <= reg_wdata;
        lbh_pkg::OFF_MSIZE: msize_reg <= reg_wdata;
        lbh_pkg::OFF_PBASE: pbase_reg <= reg_wdata;
        lbh_pkg::OFF_PCTL: pctl_reg <= reg_wdata;
        default: ;
      endcase
    end
  end

  // read data one cycle after the strobe, unmapped reads give zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        lbh_pkg::OFF_UMCS: reg_rdata <= umcs_reg;
        lbh_pkg::OFF_LMCS: reg_rdata <= lmcs_reg;
        lbh_pkg::OFF_MBASE: reg_rdata <= mbase_reg;
        lbh_pkg::OFF_MSIZE: reg_rdata <= msize_reg;
        lbh_pkg::OFF_PBASE: reg_rdata <= pbase_reg;
        lbh_pkg::OFF_PCTL: reg_rdata <= pctl_reg;
        lbh_pkg::OFF_STAT: reg_rdata <= {11'h000, test_mode, state_reg};
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // address decode: registers hold address bits 19:10 of block bounds
  assign is_mem = cyc_type[2] && (cyc_type != lbh_pkg::CYC_PASSIVE);
  assign hit_u = is_mem && (cyc_addr[19:10] >= umcs_reg[15:6]);
  assign hit_l = is_mem && (cyc_addr[19:10] <= lmcs_reg[15:6]) && (lmcs_reg[15:6] != 10'h000);
  assign m_size20 = {msize_reg[15:6], 10'h000};
  assign m_off = cyc_addr - {mbase_reg[15:6], 10'h000};
  // mid-range region split into four equal quarters
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_mid
      assign hit_m[gi] = is_mem && (m_size20 != 20'h00000) && (m_off < m_size20)
        && (m_off[19:0] >= ((m_size20 >> 2) * gi)) && (m_off < ((m_size20 >> 2) * (gi + 1)));
    end
  endgenerate
  // peripheral area of seven 128-byte blocks in io or memory space
  assign p_off = cyc_addr - {pbase_reg[15:6], 10'h000};
  generate
    for (gi = 0; gi < 7; gi++) begin : g_per
      assign hit_p[gi] = (cyc_type != lbh_pkg::CYC_PASSIVE) && (cyc_type != lbh_pkg::CYC_HALT)
        && (cyc_type != lbh_pkg::CYC_INTA)
        && (pctl_reg[lbh_pkg::PCTL_MEM_BIT] ? is_mem : !cyc_type[2])
        && (p_off[19:10] == 10'h000) && (p_off[9:7] == 3'(gi));
    end
  endgenerate

  // fixed priority: upper, lower, mid, then peripherals
  always_comb begin
    sel_next = 13'h0000;
    if (hit_u) begin
      sel_next[0] = 1'b1;
    end else if (hit_l) begin
      sel_next[1] = 1'b1;
    end else if (|hit_m) begin
      sel_next[5:2] = hit_m & (~hit_m + 4'h1);
    end else begin
      sel_next[12:6] = hit_p & (~hit_p + 7'h01);
    end
  end

  // selects load at cycle start and clear at cycle end and in grant; address latches load at cycle start, never during grant
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sel_reg <= 13'h0000;
      a1_reg <= 1'b0;
      a2_reg <= 1'b0;
    end else if (cyc_done || granted) begin
      sel_reg <= 13'h0000;
    end else if (cyc_start) begin
      sel_reg <= sel_next;
      a1_reg <= cyc_addr[1];
      a2_reg <= cyc_addr[2];
    end
  end

  // status, direction, enable and lock of the running cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status_reg <= lbh_pkg::CYC_PASSIVE;
      dir_reg <= 1'b0;
      den_n_reg <= 1'b1;
      lock_reg <= 1'b0;
    end else begin
      if (cyc_start && !granted) begin
        status_reg <= cyc_type;
        dir_reg <= (cyc_type == lbh_pkg::CYC_IOWR) || (cyc_type == lbh_pkg::CYC_MEMWR);
      end else if (cyc_done) begin
        status_reg <= lbh_pkg::CYC_PASSIVE;
      end
      // enable off in the start cycle so it is high when direction changes
      den_n_reg <= !(in_cycle_reg && cyc_data_phase && !cyc_done);
      lock_reg <= lock_req;
    end
  end

  // pin drive: status, control and bus float in grant, selects never
  always_comb begin
    bus_grant_out = granted && (state_reg != lbh_pkg::LBH_RECLAIM);
    local_bus_oe_n = test_mode || granted || (state_reg == lbh_pkg::LBH_IDLE_REL);
    status_oe_n = test_mode || granted || (state_reg == lbh_pkg::LBH_IDLE_REL);
    bus_grant_oe_n = test_mode;
    mem_select_oe_n = test_mode;
    periph_oe_n = test_mode;
    mem_select_pullup_en = !reset_seen_reg;
    cycle_status_bit2 = status_reg[2];
    cycle_status_bit1 = status_reg[1];
    cycle_status_bit0 = status_reg[0];
    upper_mem_select_n = !sel_reg[0];
    lower_mem_select_n = !sel_reg[1];
    midrange_mem_select_n = ~sel_reg[5:2];
    periph_select_n = ~sel_reg[10:6];
    periph_sel5_or_latched_addr1 = pctl_reg[lbh_pkg::PCTL_A1_BIT] ? a1_reg : !sel_reg[11];
    periph_sel6_or_latched_addr2 = pctl_reg[lbh_pkg::PCTL_A2_BIT] ? a2_reg : !sel_reg[12];
    transceiver_direction = dir_reg;
    transceiver_direction_oe_n = test_mode || granted || !reset_seen_reg;
    transceiver_output_enable_n = den_rst_reg ? 1'b1 : den_n_reg;
    transceiver_output_enable_oe_n = test_mode || granted || (!arst_n && den_float_reg);
    bus_lock_n = !lock_reg;
    bus_lock_oe_n = test_mode || granted || !reset_seen_reg;
  end

  // grant only appears where no cycle is running
  property p_grant_boundary;
    @(posedge clk) disable iff (!arst_n)
      $rose(bus_grant_out) |-> $past(req_reg) && !$past(in_cycle_reg);
  endproperty
  a_grant_boundary: assert property (p_grant_boundary) else $error("grant inside a cycle");

  property p_status_float;
    @(posedge clk) disable iff (!arst_n) bus_grant_out |-> status_oe_n && local_bus_oe_n;
  endproperty
  a_status_float: assert property (p_status_float) else $error("status driven in grant");

  sequence s_req_drop;
    granted ##1 !req_reg;
  endsequence
  property p_release;
    @(posedge clk) disable iff (!arst_n) s_req_drop |=> !bus_grant_out;
  endproperty
  a_release: assert property (p_release) else $error("grant kept after request low");

  property p_refresh;
    @(posedge clk) disable iff (!arst_n)
      (state_reg == lbh_pkg::LBH_GRANT && req_reg && refresh_pending && pctl_reg[lbh_pkg::PCTL_ENH_BIT])
      |=> !bus_grant_out;
  endproperty
  a_refresh: assert property (p_refresh) else $error("grant not dropped for refresh");

  property p_sel_driven;
    @(posedge clk) disable iff (!arst_n) granted && !test_mode |-> !mem_select_oe_n && !periph_oe_n;
  endproperty
  a_sel_driven: assert property (p_sel_driven) else $error("selects float in grant");

  property p_test_entry;
    @(posedge clk) disable iff (!arst_n)
      (!reset_seen_reg && !upper_sel_pin_in && !lower_sel_pin_in) |=> test_mode [*2];
  endproperty
  a_test_entry: assert property (p_test_entry) else $error("test mode not entered");

  property p_test_float;
    @(posedge clk) disable iff (!arst_n)
      test_mode |-> bus_grant_oe_n && mem_select_oe_n && periph_oe_n && bus_lock_oe_n;
  endproperty
  a_test_float: assert property (p_test_float) else $error("output driven in test mode");

  property p_one_select;
    @(posedge clk) disable iff (!arst_n) $onehot0(sel_reg);
  endproperty
  a_one_select: assert property (p_one_select) else $error("two selects at once");

  property p_den_dir;
    @(posedge clk) disable iff (!arst_n)
      $changed(transceiver_direction) |-> transceiver_output_enable_n;
  endproperty
  a_den_dir: assert property (p_den_dir) else $error("enable low at direction change");

  property p_a1_hold;
    @(posedge clk) disable iff (!arst_n)
      granted && $past(granted) && pctl_reg[lbh_pkg::PCTL_A1_BIT] |-> $stable(periph_sel5_or_latched_addr1);
  endproperty
  a_a1_hold: assert property (p_a1_hold) else $error("latched address moved in grant");
endmodule

// File: verif/lbh_ext_master.sv
`timescale 1ns/1ns
// far-side bus master: asks for the local bus while its user wants it
module lbh_ext_master (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic want,
  input wire logic bus_grant_out,
  output logic bus_request_in
);
  logic had_grant_reg;
  logic gave_back_reg;
  logic reclaim;

  // a grant that falls while we still ask is the device taking the bus back
  assign reclaim = had_grant_reg && !bus_grant_out && bus_request_in;

  // remember last grant level to spot a reclaim
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      had_grant_reg <= 1'b0;
    end else begin
      had_grant_reg <= bus_grant_out;
    end
  end

  // after a reclaim stay off the bus until the user drops its demand
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gave_back_reg <= 1'b0;
    end else if (!want) begin
      gave_back_reg <= 1'b0;
    end else if (reclaim) begin
      gave_back_reg <= 1'b1;
    end
  end

  // request held high for as long as the bus is needed, dropped on reclaim
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_request_in <= 1'b0;
    end else begin
      bus_request_in <= want && !gave_back_reg && !reclaim;
    end
  end
endmodule

// File: verif/local_bus_hold_and_selects_bench.sv
`timescale 1ns/1ns
module local_bus_hold_and_selects_bench;
  typedef struct {logic [2:0] t; logic [19:0] a; logic lk; logic [12:0] sel; logic dir;} lbh_row_s;
  logic clk, arst_n, want, refresh_pending, cyc_start, cyc_data_phase, cyc_done, lock_req, reg_wr, reg_rd;
  logic strap_low, req, gnt, gnt_oe_n, lb_oe_n, st2, st1, st0, st_oe_n, usel, lsel, m_oe_n, pull_en;
  logic sel5, sel6, p_oe_n, dir, dir_oe_n, ten, ten_oe_n, lock_n, lock_oe_n, test_mode;
  logic [2:0] cyc_type;
  logic [19:0] cyc_addr;
  logic [3:0] reg_addr, mid_n;
  logic [4:0] per_n;
  logic [15:0] reg_wdata, reg_rdata, rv;
  int err_count, n_compared, cycles;
  lbh_row_s rows [10];
  // board pull-up keeps released select pins high; a strap to ground wins over all
  wire upin = strap_low ? 1'b0 : (!m_oe_n ? usel : 1'b1);
  wire lpin = strap_low ? 1'b0 : (!m_oe_n ? lsel : 1'b1);
  wire [7:0] oes = {gnt_oe_n, lb_oe_n, st_oe_n, m_oe_n, p_oe_n, dir_oe_n, ten_oe_n, lock_oe_n};

  lbh_core u_dut (.clk(clk), .arst_n(arst_n), .bus_request_in(req), .refresh_pending(refresh_pending),
    .cyc_start(cyc_start), .cyc_type(cyc_type), .cyc_addr(cyc_addr), .cyc_data_phase(cyc_data_phase),
    .cyc_done(cyc_done), .lock_req(lock_req), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_grant_out(gnt), .bus_grant_oe_n(gnt_oe_n),
    .local_bus_oe_n(lb_oe_n), .cycle_status_bit2(st2), .cycle_status_bit1(st1), .cycle_status_bit0(st0),
    .status_oe_n(st_oe_n), .upper_sel_pin_in(upin), .lower_sel_pin_in(lpin), .upper_mem_select_n(usel),
    .lower_mem_select_n(lsel), .mem_select_oe_n(m_oe_n), .mem_select_pullup_en(pull_en),
    .midrange_mem_select_n(mid_n), .periph_select_n(per_n), .periph_sel5_or_latched_addr1(sel5),
    .periph_sel6_or_latched_addr2(sel6), .periph_oe_n(p_oe_n), .transceiver_direction(dir),
    .transceiver_direction_oe_n(dir_oe_n), .transceiver_output_enable_n(ten),
    .transceiver_output_enable_oe_n(ten_oe_n), .bus_lock_n(lock_n), .bus_lock_oe_n(lock_oe_n),
    .test_mode(test_mode));
  lbh_ext_master u_master (.clk(clk), .arst_n(arst_n), .want(want), .bus_grant_out(gnt), .bus_request_in(req));

  // free-running 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // hang guard, well above the roughly 150 cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      $display("[ERR] timeout expected end seen hang");
      finish_test();
    end
  end

  task automatic chk(input string nm, input logic [19:0] exp, input logic [19:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // read data are taken only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic run_cyc(input logic [2:0] t, input logic [19:0] a, input logic lk);
    @(posedge clk);
    cyc_start <= 1'b1;
    cyc_type <= t;
    cyc_addr <= a;
    lock_req <= lk;
    @(posedge clk);
    cyc_start <= 1'b0;
    cyc_data_phase <= 1'b1;
    #1;
  endtask

  task automatic end_cyc;
    @(posedge clk);
    cyc_data_phase <= 1'b0;
    cyc_done <= 1'b1;
    @(posedge clk);
    cyc_done <= 1'b0;
    lock_req <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic wait_gnt(input logic v, input int lim);
    int i;
    i = 0;
    while (gnt !== v && i < lim) begin
      @(posedge clk);
      #1;
      i++;
    end
    chk("grant", v, gnt);
  endtask

  task automatic do_reset(input logic strap);
    arst_n <= 1'b0;
    strap_low <= strap;
    #1;
    // enable is driven high until the first clock inside reset; unknown before the very first edge
    if (cycles > 0) begin
      chk("rst den drive", 2'b10, {ten, ten_oe_n});
    end
    @(posedge clk);
    #1;
    chk("rst grant", 1'b0, gnt);
    chk("rst oe", 4'b0111, {m_oe_n, dir_oe_n, lock_oe_n, ten_oe_n});
    chk("rst lvl", 4'hf, {usel, lsel, ten, pull_en});
    @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk("test mode", strap, test_mode);
    chk("pullup", 1'b0, pull_en);
    @(posedge clk);
    #1;
    chk("oe after rst", strap ? 8'hff : 8'h00, oes);
    $display("reset test done");
  endtask

  initial begin
    {want, refresh_pending, cyc_start, cyc_data_phase, cyc_done, lock_req, reg_wr, reg_rd} = 8'h00;
    cyc_type = lbh_pkg::CYC_PASSIVE;
    cyc_addr = 20'h00000;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    err_count = 0;
    n_compared = 0;
    cycles = 0;
    // memory and io selects: upper from reset value, lower programmed below
    // expected {upper, lower, mid[3:0], periph[4:0], sel5, sel6}; mid at 40000 size 64K, periph io at 04000
    rows[0] = '{lbh_pkg::CYC_MEMRD, 20'hffc10, 1'b0, 13'h0fff, 1'b0};
    rows[1] = '{lbh_pkg::CYC_MEMWR, 20'hfffff, 1'b1, 13'h0fff, 1'b1};
    rows[2] = '{lbh_pkg::CYC_FETCH, 20'h00100, 1'b0, 13'h17ff, 1'b0};
    rows[3] = '{lbh_pkg::CYC_MEMWR, 20'h00200, 1'b1, 13'h17ff, 1'b1};
    rows[4] = '{lbh_pkg::CYC_IORD, 20'h0ffc0, 1'b0, 13'h1fff, 1'b0};
    rows[5] = '{lbh_pkg::CYC_IOWR, 20'h08000, 1'b0, 13'h1fff, 1'b1};
    rows[6] = '{lbh_pkg::CYC_MEMRD, 20'h80000, 1'b0, 13'h1fff, 1'b0};
    rows[7] = '{lbh_pkg::CYC_MEMRD, 20'h44000, 1'b0, 13'h1eff, 1'b0};
    rows[8] = '{lbh_pkg::CYC_IORD, 20'h04080, 1'b0, 13'h1ff7, 1'b0};
    rows[9] = '{lbh_pkg::CYC_IOWR, 20'h04280, 1'b0, 13'h1ffd, 1'b1};
    do_reset(1'b0);
    rd(lbh_pkg::OFF_UMCS, rv);
    chk("upper reg", lbh_pkg::UMCS_RST, rv);
    wr(lbh_pkg::OFF_LMCS, 16'h0040);
    rd(lbh_pkg::OFF_LMCS, rv);
    chk("lower reg", 16'h0040, rv);
    wr(4'hf, 16'hffff);
    rd(4'hf, rv);
    chk("unmapped", 16'h0000, rv);
    $display("register test done");
    wr(lbh_pkg::OFF_MBASE, 16'h4000);
    wr(lbh_pkg::OFF_MSIZE, 16'h1000);
    wr(lbh_pkg::OFF_PBASE, 16'h0400);
    foreach (rows[i]) begin
      run_cyc(rows[i].t, rows[i].a, rows[i].lk);
      chk("mem sel", rows[i].sel[12:11], {usel, lsel});
      chk("other sel", rows[i].sel[10:0], {mid_n, per_n, sel5, sel6});
      chk("status", rows[i].t, {st2, st1, st0});
      chk("dir", rows[i].dir, dir);
      chk("lock", !rows[i].lk, lock_n);
      @(posedge clk);
      #1;
      chk("xcvr en", 1'b0, ten);
      end_cyc();
      chk("idle", 5'h1f, {usel, lsel, st2, st1, st0});
    end
    $display("select table test done");
    // grant must wait for the running cycle to end
    run_cyc(lbh_pkg::CYC_MEMRD, 20'hffc10, 1'b0);
    want = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("grant mid cycle", 1'b0, gnt);
    end_cyc();
    wait_gnt(1'b1, 4);
    chk("oe in grant", 8'h67, oes);
    rd(lbh_pkg::OFF_STAT, rv);
    chk("stat reg", 16'h0002, rv);
    run_cyc(lbh_pkg::CYC_MEMRD, 20'hffc10, 1'b0);
    chk("sel in grant", 2'b11, {usel, lsel});
    end_cyc();
    want = 1'b0;
    wait_gnt(1'b0, 4);
    chk("float kept", 1'b1, lb_oe_n);
    run_cyc(lbh_pkg::CYC_MEMRD, 20'hffc10, 1'b0);
    chk("bus driven", 1'b0, lb_oe_n);
    end_cyc();
    $display("hold test done");
    // latched address bits, then a refresh reclaim in enhanced mode
    wr(lbh_pkg::OFF_PCTL, 16'h000f);
    run_cyc(lbh_pkg::CYC_MEMRD, 20'h04080, 1'b0);
    chk("mem periph", 5'h1d, per_n);
    end_cyc();
    run_cyc(lbh_pkg::CYC_MEMRD, 20'h00102, 1'b0);
    end_cyc();
    chk("latched addr", 2'b01, {sel6, sel5});
    want = 1'b1;
    wait_gnt(1'b1, 6);
    chk("latched held", 2'b01, {sel6, sel5});
    refresh_pending = 1'b1;
    wait_gnt(1'b0, 6);
    repeat (3) @(posedge clk);
    #1;
    chk("request back", 1'b0, req);
    want = 1'b0;
    refresh_pending = 1'b0;
    $display("refresh test done");
    // test mode floats everything, even with traffic, until a new reset
    do_reset(1'b1);
    want = 1'b1;
    run_cyc(lbh_pkg::CYC_MEMWR, 20'hffc10, 1'b1);
    chk("test oe", 8'hff, oes);
    end_cyc();
    want = 1'b0;
    do_reset(1'b0);
    $display("test mode test done");
    finish_test();
  end
endmodule
